// ### design/flash_host_pkg.sv
/*
  Constants for the flash write-status host controller: command codes,
  status bit positions, controller register offsets and strobe timing.
  Assumes a 50 MHz controller clock and a byte-wide asynchronous flash.
*/
package flash_host_pkg;
  // controller register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  // control fields: command code in [3:0], go bit
  localparam int CTRL_GO_BIT = 8;
  // commands taken by the controller
  localparam logic [3:0] CMD_READ     = 4'h0;
  localparam logic [3:0] CMD_RESET    = 4'h1;
  localparam logic [3:0] CMD_PROGRAM  = 4'h2;
  localparam logic [3:0] CMD_CHIP_ERS = 4'h3;
  localparam logic [3:0] CMD_SECT_ERS = 4'h4;
  localparam logic [3:0] CMD_SUSPEND  = 4'h5;
  localparam logic [3:0] CMD_RESUME   = 4'h6;
  localparam logic [3:0] CMD_AUTOSEL  = 4'h7;
  localparam logic [3:0] CMD_POLL     = 4'h8;
  // flash command bytes
  localparam logic [7:0] FL_UNLOCK1  = 8'haa;
  localparam logic [7:0] FL_UNLOCK2  = 8'h55;
  localparam logic [7:0] FL_AUTOSEL  = 8'h90;
  localparam logic [7:0] FL_PROGRAM  = 8'ha0;
  localparam logic [7:0] FL_ERASE    = 8'h80;
  localparam logic [7:0] FL_CHIP     = 8'h10;
  localparam logic [7:0] FL_SECTOR   = 8'h30;
  localparam logic [7:0] FL_SUSPEND  = 8'hb0;
  localparam logic [7:0] FL_RESUME   = 8'h30;
  localparam logic [7:0] FL_RESET    = 8'hf0;
  // status bit positions on the byte lines
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE1    = 6;
  localparam int LIMIT_BIT  = 5;
  localparam int WINDOW_BIT = 3;
  localparam int TOGGLE2    = 2;
  // address widths and sector fields
  localparam int ADDR_W      = 21;
  localparam int SECT_LSB    = 16;
  localparam int GROUP_LSB   = 18;
  // strobe timing: each phase held at least this long
  localparam int CLK_MHZ      = 50;
  localparam int STROBE_NS    = 80;
  localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
endpackage : flash_host_pkg

// ### design/flash_host_ctrl.sv
/*
  Host-side controller that drives a byte-wide asynchronous flash through
  chip select, write strobe and output enable, sends command sequences and
  watches write-operation status by polling and toggle reads.
  Assumes the flash ready/busy pin is pulled up outside; byte lines are a
  two-way bus resolved by the surroundings from o_data_oe_n.
*/
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) flash latches address late, data early
// (R2) sector picked by top five address bits
// (R3) group picked by top three address bits
// (R4) command cycles are writes except reads
// (R5) upper ten address bits ignored in unlocks
// (R6) host sends reset after autoselect or limit
// (R7) autoselect fourth cycle is a read
// (R8) group verify reads 00h or 01h
// (R9) suspend only during sector erase
// (R10) resume only while suspended
// (R11) polling bit inverted until program done
// (R12) protected program: status about 2 us
// (R13) erase polling bit 0, then 1
// (R14) all protected erase: status about 100 us
// (R15) host rereads data after polling flips
// (R16) ready_busy_flag open drain, low when busy
// (R17) first toggle bit flips each busy read
// (R18) first toggle valid after last write
// (R19) protected ops toggle briefly then stop
// (R20) toggle stops on suspend, resumes programming
// (R21) second toggle flips in erasing sectors
// (R22) limit bit high marks failed operation
// (R23) toggle bits invert per read, then freeze
module flash_host_ctrl #(
  parameter int ADDR_W = flash_host_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // software register port
  input  wire logic [3:0]        i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [31:0]       o_reg_rdata,
  // flash strobes and address
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic [ADDR_W-1:0]      o_addr,
  // flash byte lines, output enable low while driving
  input  wire logic [7:0]        i_byte_lines,
  output logic      [7:0]        o_byte_lines,
  output logic                   o_data_oe_n,
  // flash ready_busy_flag pin
  input  wire logic              i_ready_busy_flag
);

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT, ST_DONE} state_e;

  state_e              state;
  logic [3:0]          cmd;
  logic [ADDR_W-1:0]   addr_reg;
  logic [7:0]          wdata_reg;
  logic [2:0]          step;
  logic [2:0]          last_step;
  logic                step_read;
  logic [3:0]          timer;
  logic                busy;
  logic [7:0]          rdata;
  logic [7:0]          prev_read;
  logic                prev_valid;
  logic                toggling;
  logic                toggling2;
  logic                poll_done;
  logic                limit_hit;
  logic                limit_pend;
  logic                toggle_seen;
  logic                need_reset;
  logic                autosel_mode;
  logic [1:0]          rb_sync;
  logic [7:0]          d_sync1;
  logic [7:0]          d_sync2;
  logic [ADDR_W-1:0]   cyc_addr;
  logic [7:0]          cyc_data;

  // sequence length function: index of the last bus cycle of a command
  function automatic logic [2:0] seq_len(input logic [3:0] c);
    unique case (c)
      flash_host_pkg::CMD_READ,
      flash_host_pkg::CMD_POLL,
      flash_host_pkg::CMD_RESET,
      flash_host_pkg::CMD_SUSPEND,
      flash_host_pkg::CMD_RESUME:   seq_len = 3'h0;
      flash_host_pkg::CMD_PROGRAM,
      flash_host_pkg::CMD_AUTOSEL:  seq_len = 3'h3;
      default:                      seq_len = 3'h5;
    endcase
  endfunction : seq_len

  // address and data of the current bus cycle
  always_comb begin
    cyc_addr = '0;                                  // unlocks use zero upper bits [R5]
    cyc_data = flash_host_pkg::FL_UNLOCK1;
    unique case (step)
      3'h0: cyc_data = flash_host_pkg::FL_UNLOCK1;
      3'h1: cyc_data = flash_host_pkg::FL_UNLOCK2;
      3'h2: begin
        if (cmd == flash_host_pkg::CMD_PROGRAM) cyc_data = flash_host_pkg::FL_PROGRAM;
        else if (cmd == flash_host_pkg::CMD_AUTOSEL) cyc_data = flash_host_pkg::FL_AUTOSEL;
        else cyc_data = flash_host_pkg::FL_ERASE;
      end
      3'h3: begin
        cyc_data = (cmd == flash_host_pkg::CMD_PROGRAM) ? wdata_reg : flash_host_pkg::FL_UNLOCK1;
        if (cmd != flash_host_pkg::CMD_CHIP_ERS && cmd != flash_host_pkg::CMD_SECT_ERS)
          cyc_addr = addr_reg;                      // program or verify address
      end
      3'h4: cyc_data = flash_host_pkg::FL_UNLOCK2;
      default: begin
        if (cmd == flash_host_pkg::CMD_SECT_ERS) begin
          cyc_data = flash_host_pkg::FL_SECTOR;
          cyc_addr = {addr_reg[ADDR_W-1:flash_host_pkg::SECT_LSB],
                      (flash_host_pkg::SECT_LSB)'(0)}; // sector by top bits [R2]
        end else begin
          cyc_data = flash_host_pkg::FL_CHIP;
        end
      end
    endcase
    if (last_step == 3'h0) begin
      cyc_addr = addr_reg;
      unique case (cmd)
        flash_host_pkg::CMD_RESET:   cyc_data = flash_host_pkg::FL_RESET;
        flash_host_pkg::CMD_SUSPEND: cyc_data = flash_host_pkg::FL_SUSPEND;
        flash_host_pkg::CMD_RESUME:  cyc_data = flash_host_pkg::FL_RESUME;
        default:                     cyc_data = wdata_reg;
      endcase
    end
  end

  // a read is the last cycle of read, poll and autoselect [R7] [R4]
  assign step_read = (cmd == flash_host_pkg::CMD_READ) || (cmd == flash_host_pkg::CMD_POLL) ||
                     (cmd == flash_host_pkg::CMD_AUTOSEL && step == last_step);

  // pin synchronisers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rb_sync <= 2'h3;
      d_sync1 <= 8'h00;
      d_sync2 <= 8'h00;
    end else begin
      rb_sync <= {rb_sync[0], i_ready_busy_flag};
      d_sync1 <= i_byte_lines;
      d_sync2 <= d_sync1;
    end
  end

  // bus sequencer: one strobe per bus cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state       <= ST_IDLE;
      step        <= 3'h0;
      last_step   <= 3'h0;
      timer       <= 4'h0;
      o_ce_n      <= 1'b1;
      o_we_n      <= 1'b1;
      o_oe_n      <= 1'b1;
      o_addr      <= '0;
      o_byte_lines <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (busy) begin
            step      <= 3'h0;
            last_step <= seq_len(cmd);
            state     <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // address stable before strobe falls, latched at later edge [R1]
          o_addr       <= cyc_addr;
          o_byte_lines <= cyc_data;
          o_data_oe_n  <= step_read;
          o_ce_n       <= 1'b0;
          timer        <= flash_host_pkg::STROBE_CNT;
          state        <= ST_STROBE;
        end
        ST_STROBE: begin
          o_we_n <= step_read;
          o_oe_n <= !step_read;
          if (timer == 4'h0) state <= ST_HOLD;
          else timer <= timer - 4'h1;
        end
        ST_HOLD: begin
          // write strobe rises first, data held past it [R1]
          o_we_n <= 1'b1;
          o_oe_n <= 1'b1;
          timer  <= flash_host_pkg::STROBE_CNT;
          state  <= ST_NEXT;
        end
        ST_NEXT: begin
          o_ce_n <= 1'b1;
          if (timer != 4'h0) begin
            timer <= timer - 4'h1;
          end else begin
            o_data_oe_n <= 1'b1;
            if (step == last_step) state <= ST_DONE;
            else begin
              step  <= step + 3'h1;
              state <= ST_SETUP;
            end
          end
        end
        ST_DONE: state <= ST_IDLE;
      endcase
    end
  end

  // first toggle bit moved between the last two reads of one poll run
  assign toggle_seen = prev_valid && (prev_read[flash_host_pkg::TOGGLE1] !=
                                      d_sync2[flash_host_pkg::TOGGLE1]);

  // commands, status of the last read and toggle tracking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy         <= 1'b0;
      cmd          <= flash_host_pkg::CMD_READ;
      addr_reg     <= '0;
      wdata_reg    <= 8'h00;
      rdata        <= 8'h00;
      prev_read    <= 8'h00;
      prev_valid   <= 1'b0;
      toggling     <= 1'b0;
      toggling2    <= 1'b0;
      poll_done    <= 1'b0;
      limit_hit    <= 1'b0;
      limit_pend   <= 1'b0;
      autosel_mode <= 1'b0;
    end else begin
      if (i_reg_wr && !busy) begin
        unique case (i_reg_addr)
          flash_host_pkg::REG_ADDR:  addr_reg  <= i_reg_wdata[ADDR_W-1:0];
          flash_host_pkg::REG_WDATA: wdata_reg <= i_reg_wdata[7:0];
          flash_host_pkg::REG_CTRL: begin
            cmd  <= i_reg_wdata[3:0];
            busy <= i_reg_wdata[flash_host_pkg::CTRL_GO_BIT];
            if (i_reg_wdata[3:0] != flash_host_pkg::CMD_POLL) prev_valid <= 1'b0;
          end
          default: ;
        endcase
      end
      if (state == ST_DONE) begin
        busy <= 1'b0;
        if (cmd == flash_host_pkg::CMD_AUTOSEL) autosel_mode <= 1'b1;
        if (cmd == flash_host_pkg::CMD_RESET) begin
          autosel_mode <= 1'b0;                     // reset returns to array reads [R6]
          limit_hit    <= 1'b0;
        end
      end
      // capture read data at the end of the read strobe
      if (state == ST_HOLD && step_read) begin
        rdata      <= d_sync2;
        prev_read  <= d_sync2;
        prev_valid <= 1'b1;
        // compare toggle bits of two reads in a row [R17] [R21] [R23]
        toggling  <= toggle_seen;
        toggling2 <= prev_valid && (prev_read[flash_host_pkg::TOGGLE2] !=
                                    d_sync2[flash_host_pkg::TOGGLE2]);
        // polling bit equal to expected datum means done [R11] [R13]
        poll_done <= d_sync2[flash_host_pkg::POLL_BIT] == wdata_reg[flash_host_pkg::POLL_BIT];
        // limit bit beside a toggle needs one more toggling read: the op may
        // just have ended and the byte now shows array data with bit 5 set
        limit_pend <= toggle_seen && d_sync2[flash_host_pkg::LIMIT_BIT];
        if (limit_pend && toggle_seen) limit_hit <= 1'b1;  // failed op, reset due [R22] [R6]
      end
    end
  end

  // a limit or autoselect leaves the flash needing the reset command [R6]
  assign need_reset = limit_hit || autosel_mode;

  // register read data, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        flash_host_pkg::REG_CTRL:   o_reg_rdata <= {23'h0, busy, 4'h0, cmd};
        flash_host_pkg::REG_ADDR:   o_reg_rdata <= {(32-ADDR_W)'(0), addr_reg};
        flash_host_pkg::REG_WDATA:  o_reg_rdata <= {24'h0, wdata_reg};
        // ready_busy_flag low means the flash is busy [R16]
        flash_host_pkg::REG_STATUS: o_reg_rdata <= {25'h0, need_reset, limit_hit, poll_done,
                                                    toggling2, toggling, !rb_sync[1], busy};
        // software rereads after polling flips before trusting data [R15]
        flash_host_pkg::REG_RDATA:  o_reg_rdata <= {24'h0, rdata};
        default:                    o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : flash_host_ctrl

// ### verif/flash_host_checker.sv
/* port checker for the flash host controller.
   bound onto every flash_host_ctrl instance; single clock domain. */
`timescale 1ns/1ps
module flash_host_checker #(
  parameter int ADDR_W = 21
) (
  // clock, reset and watched ports
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [3:0]        i_reg_addr,
  input wire logic              i_reg_rd,
  input wire logic [31:0]       o_reg_rdata,
  input wire logic              o_ce_n,
  input wire logic              o_we_n,
  input wire logic              o_oe_n,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [7:0]        o_byte_lines,
  input wire logic              o_data_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // strobes parked while reset holds, so the flash sees no stray cycle
  a_reset_idle: assert property (disable iff (1'b0) i_rst |=> o_ce_n && o_we_n && o_oe_n && o_data_oe_n)
    else $error("strobes not idle after reset");
  a_one_strobe: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and read strobe low together");
  a_strobe_in_ce: assert property (!o_we_n || !o_oe_n |-> !o_ce_n)
    else $error("strobe low without chip select");
  a_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*5])
    else $error("write strobe too short");
  a_addr_hold: assert property (!o_we_n && $past(!o_we_n) |-> $stable(o_addr) && $stable(o_byte_lines))
    else $error("address or data moved under write strobe");
  a_write_drives: assert property (!o_we_n |-> !o_data_oe_n)
    else $error("write strobe without driven data");
  a_read_floats: assert property (!o_oe_n |-> o_data_oe_n)
    else $error("byte lines driven during read");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside read reply cycle");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 4'h4 |=> o_reg_rdata == 32'h0)
    else $error("unmapped register read not zero");
endmodule : flash_host_checker

bind flash_host_ctrl flash_host_checker #(.ADDR_W(ADDR_W)) flash_host_checker_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
  .o_addr(o_addr), .o_byte_lines(o_byte_lines), .o_data_oe_n(o_data_oe_n));

// ### verif/flash_model.sv
/* behavioural flash device on the far side of the host controller.
   no clock: reacts to strobe edges; ready pin pull-up is implied. */
`timescale 1ns/1ps
module flash_model #(
  parameter int         PROG_NS       = 3000,
  parameter int         ERASE_NS      = 6000,
  // one protected sector group; status windows of protected ops
  parameter int         PROT_PROG_NS  = 2000,
  parameter int         PROT_ERASE_NS = 100000,
  parameter logic [2:0] PROT_GROUP    = 3'h7
) (
  // strobes, address and byte lines
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [20:0] i_addr,
  input  wire logic [7:0]  i_data,
  output logic      [7:0]  o_data,
  // ready pin, low pulls the line down
  output logic             o_ready_busy_flag
);
  logic [7:0]  mem [int];
  logic [20:0] la, pa, ra;
  logic [7:0]  pv;
  logic [4:0]  esect;
  logic        busy = 0, erasing = 0, susp = 0, t1 = 0, t2 = 0;
  logic        autosel = 0, lim = 0;
  int          step = 0;
  initial o_data = 8'h00;
  // low while programming or actively erasing
  assign o_ready_busy_flag = !(busy || (erasing && !susp));
  // ce is already low, so this is the later falling edge
  always @(negedge i_we_n) la = i_addr;
  // data taken on the first rising edge; command decode
  always @(posedge i_we_n) if (!i_ce_n) begin
    case (step)
      0: begin
        if (i_data == 8'haa) step = 1;
        else if (i_data == 8'hb0 && erasing) susp = 1;
        else if (i_data == 8'h30 && susp) susp = 0;
        else if (i_data == 8'hf0) begin  // back to array reads
          autosel = 0;
          if (lim) begin
            lim = 0;
            busy = 0;
          end
        end
      end
      1, 4: step = (i_data == 8'h55) ? step + 1 : 0;
      2: begin
        if (i_data == 8'h90) autosel = 1;  // fourth cycle is then a read
        step = (i_data == 8'ha0) ? 7 : (i_data == 8'h80) ? 3 : 0;
      end
      3: step = (i_data == 8'haa) ? 4 : 0;
      5: begin  // sector picked by top five bits
        step = 0;
        esect = la[20:16];
        erasing = 1;
        fork erase_run(); join_none
      end
      default: begin
        step = 0;
        pa = la;
        pv = i_data;
        busy = 1;
        fork prog_run(); join_none
      end
    endcase
  end
  // protected group: status only, nothing written; 0 to 1 fails and stays busy
  task automatic prog_run();
    logic prot;
    prot = pa[20:18] == PROT_GROUP;
    #(prot ? PROT_PROG_NS : PROG_NS);
    if (!prot && mem.exists(int'(pa)) && (pv & ~mem[int'(pa)]) != 8'h00) lim = 1;
    else begin
      if (!prot) mem[pa] = pv;
      busy = 0;
    end
  endtask : prog_run
  // erase progress halts while suspended; a protected sector only shows status
  task automatic erase_run();
    if (esect[4:2] == PROT_GROUP) #(PROT_ERASE_NS);
    else begin
      repeat (ERASE_NS / 100) begin
        #100;
        wait (!susp);
      end
    end
    erasing = 0;
  endtask : erase_run
  // status replaces array data while busy
  always @(negedge i_oe_n) if (!i_ce_n) begin
    ra = i_addr;
    if (autosel) o_data = (ra[7:0] == 8'h02) ? {7'h00, ra[20:18] == PROT_GROUP} : 8'h00;
    else if (busy) o_data = {~pv[7], t1, lim, 5'h00};
    else if (erasing && ra[20:16] == esect) o_data = {susp, t1, 3'h0, t2, 2'h0};
    else o_data = mem.exists(int'(ra)) ? mem[int'(ra)] : 8'hff;
  end
  // toggles flip at each read end from the command on, frozen when idle
  always @(posedge i_oe_n) if (!i_ce_n) begin
    if (busy || (erasing && !susp)) t1 = ~t1;
    if (erasing && ra[20:16] == esect) t2 = ~t2;
    o_data = ~o_data;  // released lines must not keep the last value
  end
endmodule : flash_model

// ### verif/testbench.sv
/* self-checking bench: host controller against a behavioural flash.
   register port driven at rising edges; byte lines resolved here. */
`timescale 1ns/1ps
module testbench;
  logic        i_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, s;
  logic        o_ce_n, o_we_n, o_oe_n, o_data_oe_n, rb;
  logic [20:0] o_addr, a;
  logic [7:0]  o_byte_lines, fl_data, d;
  logic [7:0]  exp_mem [int];
  int          error_cnt = 0, total_checks = 0, seed = 38154;
  localparam logic [2:0] PROT_GROUP = 3'h7;  // the one protected sector group
  // two-way byte lines: controller wins while it enables its driver
  wire  [7:0]  bus = !o_data_oe_n ? o_byte_lines : fl_data;
  initial forever #10 i_clk = ~i_clk;
  flash_host_ctrl flash_host_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_addr(o_addr), .i_byte_lines(bus), .o_byte_lines(o_byte_lines),
    .o_data_oe_n(o_data_oe_n), .i_ready_busy_flag(rb));
  flash_model #(.PROT_GROUP(PROT_GROUP)) flash_model_i (.i_ce_n(o_ce_n), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_addr(o_addr), .i_data(o_byte_lines), .o_data(fl_data),
    .o_ready_busy_flag(rb));
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  // reply stands only in the cycle after the strobe
  task rd(input logic [3:0] ad, output logic [31:0] v);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    v = o_reg_rdata;
  endtask : rd
  // start a command, then wait for the busy bit to drop; s keeps status
  task op(input logic [3:0] c);
    int n;
    wr(flash_host_pkg::REG_CTRL, (32'h1 << flash_host_pkg::CTRL_GO_BIT) | 32'(c));
    for (n = 0; n < 500; n++) begin
      rd(flash_host_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 500) begin
      error_cnt++;
      stop_test();
    end
  endtask : op
  // poll until status bit b turns true, then one more read
  task wait_done(input int b);
    int n;
    for (n = 0; n < 60; n++) begin
      op(flash_host_pkg::CMD_POLL);
      if (s[b] === 1'b1) break;
    end
    if (n == 60) begin
      error_cnt++;
      stop_test();
    end
    op(flash_host_pkg::CMD_POLL);
  endtask : wait_done
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(flash_host_pkg::REG_STATUS, s);
    chk("status after reset", s, 32'h0);
    rd(4'hf, s);
    chk("unmapped read", s, 32'h0);
    // programs kept out of the upper half, where the erase lands
    repeat (3) begin
      a = {1'b0, 20'($random(seed))};
      d = 8'($random(seed)) & 8'hfe;  // bit 0 low for the failing reprogram below
      exp_mem[int'(a)] = d;
      wr(flash_host_pkg::REG_ADDR, 32'(a));
      wr(flash_host_pkg::REG_WDATA, 32'(d));
      op(flash_host_pkg::CMD_PROGRAM);
      op(flash_host_pkg::CMD_POLL);
      op(flash_host_pkg::CMD_POLL);
      chk("program status", s[6:1], 6'h03);
      wait_done(4);
      chk("program done", s[6:1], 6'h08);
      op(flash_host_pkg::CMD_READ);
      rd(flash_host_pkg::REG_RDATA, s);
      chk("program data", s[7:0], exp_mem[int'(a)]);
    end
    // reprogramming a 0 bit to 1 fails: limit bit, then reset needed
    wr(flash_host_pkg::REG_WDATA, 32'hff);
    op(flash_host_pkg::CMD_PROGRAM);
    wait_done(5);
    chk("limit status", s[6:5], 2'h3);
    op(flash_host_pkg::CMD_RESET);
    chk("limit cleared", s[6:5], 2'h0);
    op(flash_host_pkg::CMD_READ);
    rd(flash_host_pkg::REG_RDATA, s);
    chk("data kept after fail", s[7:0], exp_mem[int'(a)]);
    // program into the protected group: status only, array left erased
    a = {PROT_GROUP, 18'($random(seed))};
    d = {1'b1, 7'($random(seed))};  // bit 7 high so polling ends on erased data
    wr(flash_host_pkg::REG_ADDR, 32'(a));
    wr(flash_host_pkg::REG_WDATA, 32'(d));
    op(flash_host_pkg::CMD_PROGRAM);
    op(flash_host_pkg::CMD_POLL);
    op(flash_host_pkg::CMD_POLL);
    chk("protected status", s[6:1], 6'h03);
    wait_done(4);
    op(flash_host_pkg::CMD_READ);
    rd(flash_host_pkg::REG_RDATA, s);
    chk("protected data", s[7:0], 8'hff);
    // sector erase, suspended and resumed in mid-run, outside the protected group
    a = {2'b10, 3'($random(seed)), 16'h0000};
    wr(flash_host_pkg::REG_ADDR, 32'(a));
    wr(flash_host_pkg::REG_WDATA, 32'hff);
    op(flash_host_pkg::CMD_SECT_ERS);
    op(flash_host_pkg::CMD_POLL);
    op(flash_host_pkg::CMD_POLL);
    chk("erase status", s[6:1], 6'h07);
    op(flash_host_pkg::CMD_SUSPEND);
    op(flash_host_pkg::CMD_POLL);
    op(flash_host_pkg::CMD_POLL);
    chk("suspend status", s[6:1], 6'h0c);
    op(flash_host_pkg::CMD_RESUME);
    wait_done(4);
    chk("erase done", s[6:1], 6'h08);
    // group verify in autoselect: one protected group, one open group
    for (int k = 0; k < 2; k++) begin
      a = {(k == 0) ? PROT_GROUP : 3'h0, 10'h000, 8'h02};
      wr(flash_host_pkg::REG_ADDR, 32'(a));
      op(flash_host_pkg::CMD_AUTOSEL);
      chk("autoselect pending", s[6], 1'b1);
      rd(flash_host_pkg::REG_RDATA, s);
      chk("group verify", s[7:0], (k == 0) ? 8'h01 : 8'h00);
      op(flash_host_pkg::CMD_RESET);
      chk("idle after reset cmd", s[6], 1'b0);
    end
    stop_test();
  end
endmodule : testbench
